/* src/mmsa_defines.vh */
`ifndef MMSA_DEFINES_VH
`define MMSA_DEFINES_VH
// ==========================================
// geometry
`define MMSA_NM 4
`define MMSA_NS 2
`define MMSA_MW 2
// ==========================================
// register group byte addresses (register n of a group at base + n * 4)
`define MMSA_ADDR_W 8
`define MMSA_MCFG_BASE 8'h00
`define MMSA_SCFG_BASE 8'h10
`define MMSA_PRI_BASE 8'h20
`define MMSA_STAT_BASE 8'h30
// ==========================================
// slave configuration register fields
`define MMSA_SLOT_LSB 0
`define MMSA_SLOT_W 8
`define MMSA_DEFM_TYPE_LSB 16
`define MMSA_DEFM_ID_LSB 18
`define MMSA_ARB_TYPE_BIT 24
`define MMSA_SCFG_RESET 32'h0000_0010
// ==========================================
// master configuration register fields
`define MMSA_UBRK_W 3
`define MMSA_UBRK_INF 3'h0
`define MMSA_UBRK_4 3'h2
`define MMSA_UBRK_8 3'h3
`define MMSA_UBRK_16 3'h4
`define MMSA_MCFG_RESET 3'h0
// ==========================================
// encodings
`define MMSA_ARB_RR 1'b0
`define MMSA_ARB_FIXED 1'b1
`define MMSA_DEFM_NONE 2'h0
`define MMSA_DEFM_LAST 2'h1
`define MMSA_DEFM_FIXED 2'h2
`define MMSA_HTRANS_IDLE 2'h0
`define MMSA_HTRANS_BUSY 2'h1
`define MMSA_HTRANS_NSEQ 2'h2
`define MMSA_HTRANS_SEQ 2'h3
`define MMSA_HBURST_SINGLE 3'h0
`define MMSA_HBURST_INCR 3'h1
`endif

/* src/mmsa_arbiter.v */
`timescale 1ns/100ps
// Overview of operation
// - one independent arbiter per slave port
// - round-robin or fixed priority, round-robin at reset
// - slave config field picks arbitration scheme
// - per-slave default master combines with either scheme
// - re-arbitrate when slave idle or unaccessed
// - re-arbitrate during single access
// - re-arbitrate on last beat of fixed burst
// - re-arbitrate when slot counter expires
// - infinite setting never breaks INCR burst at a beat count
// - finite setting breaks INCR at 4/8/16 beats
// - break option set per master config
// - load slot counter at burst start, decrement
// - counter zero allows break after current beat
// - simultaneous requests in round-robin: first master after the last granted one wins, master 0 after reset
// - later grants rotate round-robin
module mmsa_arbiter (
    // clock and reset
    input wire clk_sys_in,
    input wire nrst_in,
    // register port
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    // per-master request towards each slave, flat [s*NM+m]
    input wire [7:0] req_in,
    // per-slave transfer view of connected master
    input wire [3:0] htrans_in,
    input wire [5:0] hburst_in,
    input wire [1:0] hready_in,
    // per-slave grant, one-hot masters, flat [s*NM+m]
    output reg [7:0] grant_out,
    output reg [1:0] owned_out
);
`include "mmsa_defines.vh"
localparam NM = `MMSA_NM;
localparam NS = `MMSA_NS;

// ==========================================
// address decode
reg [NM-1:0] hit_mcfg;
reg [NS-1:0] hit_scfg;
reg [NS-1:0] hit_pri;
reg [NS-1:0] hit_stat;
integer j;

always @* begin
    hit_mcfg = 4'h0;
    hit_scfg = 2'h0;
    hit_pri = 2'h0;
    hit_stat = 2'h0;
    for (j = 0; j < NM; j = j + 1) begin
        hit_mcfg[j] = reg_addr_in == `MMSA_MCFG_BASE + {j[5:0], 2'b00};
    end

    for (j = 0; j < NS; j = j + 1) begin
        hit_scfg[j] = reg_addr_in == `MMSA_SCFG_BASE + {j[5:0], 2'b00};
        hit_pri[j] = reg_addr_in == `MMSA_PRI_BASE + {j[5:0], 2'b00};
        hit_stat[j] = reg_addr_in == `MMSA_STAT_BASE + {j[5:0], 2'b00};
    end
end

// ==========================================
// configuration registers
reg [2:0] ubrk_reg [0:NM-1];
reg [31:0] scfg_reg [0:NS-1];
reg [7:0] pri_reg [0:NS-1];
reg [NM*NS-1:0] grant_reg;
reg [NS-1:0] owned_reg;
reg [1:0] last_reg [0:NS-1];
reg [7:0] slot_reg [0:NS-1];
reg [4:0] beat_reg [0:NS-1];
integer i;

always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
        for (i = 0; i < NM; i = i + 1) begin
            ubrk_reg[i] <= `MMSA_MCFG_RESET;
        end
        for (i = 0; i < NS; i = i + 1) begin
            scfg_reg[i] <= `MMSA_SCFG_RESET;
            pri_reg[i] <= 8'h00;
        end
    end else if (reg_wr_in) begin
        for (i = 0; i < NM; i = i + 1) begin
            if (hit_mcfg[i]) begin
                ubrk_reg[i] <= reg_wdata_in[2:0];
            end
        end
        for (i = 0; i < NS; i = i + 1) begin
            if (hit_scfg[i]) begin
                scfg_reg[i] <= reg_wdata_in & 32'h010F_00FF;
            end
            if (hit_pri[i]) begin
                pri_reg[i] <= reg_wdata_in[7:0];
            end
        end
    end
end

// ==========================================
// slave configuration fields
reg [7:0] slot_lim_w [0:NS-1];
reg [1:0] defm_type_w [0:NS-1];
reg [1:0] defm_id_w [0:NS-1];
reg arb_fixed_w [0:NS-1];
reg [31:0] stat_w [0:NS-1];
integer f;
integer g;

always @* begin
    for (f = 0; f < NS; f = f + 1) begin
        slot_lim_w[f] = scfg_reg[f][`MMSA_SLOT_LSB +: `MMSA_SLOT_W];
        defm_type_w[f] = scfg_reg[f][`MMSA_DEFM_TYPE_LSB +: 2];
        defm_id_w[f] = scfg_reg[f][`MMSA_DEFM_ID_LSB +: 2];
        arb_fixed_w[f] = scfg_reg[f][`MMSA_ARB_TYPE_BIT] == `MMSA_ARB_FIXED;
    end
end

// ==========================================
// status words
always @* begin
    for (g = 0; g < NS; g = g + 1) begin
        stat_w[g] = {24'h00_0000, owned_reg[g], slot_reg[g] == 8'h00, 2'h0, grant_reg[g*NM +: NM]};
    end
end

// ==========================================
// read port
reg [31:0] rd_next;
integer r;
always @* begin
    rd_next = 32'h0000_0000;
    for (r = 0; r < NM; r = r + 1) begin
        if (hit_mcfg[r]) begin
            rd_next = {29'h0000_0000, ubrk_reg[r]};
        end
    end
    for (r = 0; r < NS; r = r + 1) begin
        if (hit_scfg[r]) begin
            rd_next = scfg_reg[r];
        end
        if (hit_pri[r]) begin
            rd_next = {24'h00_0000, pri_reg[r]};
        end
        if (hit_stat[r]) begin
            rd_next = stat_w[r];
        end
    end
end

always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
        reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
        reg_rdata_out <= rd_next;
    end else begin
        reg_rdata_out <= 32'h0000_0000;
    end
end

// ==========================================
// per-slave arbitration, one pass per slave
reg [NM*NS-1:0] grant_next;
reg [NS-1:0] owned_next;
reg [1:0] last_next [0:NS-1];
reg [7:0] slot_next [0:NS-1];
reg [4:0] beat_next [0:NS-1];
reg [1:0] cur;
reg [1:0] sel;
reg [1:0] tr;
reg [2:0] hb;
reg [2:0] ul;
reg [3:0] rq;
reg [4:0] lim;
reg [1:0] pv;
reg [1:0] bestp;
reg found;
reg may_arb;
reg active;
reg at_bound;
reg slot_out;
integer s;
integer k;
integer m;

always @* begin
    grant_next = grant_reg;
    owned_next = owned_reg;
    cur = 2'h0;
    sel = 2'h0;
    tr = 2'h0;
    hb = 3'h0;
    ul = 3'h0;
    rq = 4'h0;
    lim = 5'h00;
    pv = 2'h0;
    bestp = 2'h0;
    found = 1'b0;
    may_arb = 1'b0;
    active = 1'b0;
    at_bound = 1'b0;
    slot_out = 1'b0;
    for (s = 0; s < NS; s = s + 1) begin
        last_next[s] = last_reg[s];
        slot_next[s] = slot_reg[s];
        beat_next[s] = beat_reg[s];
        cur = 2'h0;
        for (k = 0; k < NM; k = k + 1) begin
            if (grant_reg[s*NM+k]) begin
                cur = k[1:0];
            end
        end
        tr = htrans_in[2*s +: 2];
        hb = hburst_in[3*s +: 3];
        ul = ubrk_reg[cur];
        rq = req_in[s*NM +: NM];
        active = owned_reg[s] && (tr != `MMSA_HTRANS_IDLE);

        // burst beat and slot tracking
        if (active && hready_in[s] && tr != `MMSA_HTRANS_BUSY) begin
            if (tr == `MMSA_HTRANS_NSEQ) begin
                slot_next[s] = slot_lim_w[s];
                beat_next[s] = 5'h01;
            end else begin
                beat_next[s] = beat_reg[s] + 5'h01;
                if (slot_reg[s] != 8'h00) begin
                    slot_next[s] = slot_reg[s] - 8'h01;
                end
            end
        end else if (active && slot_reg[s] != 8'h00) begin
            slot_next[s] = slot_reg[s] - 8'h01;
        end
        case (hb)
            3'h2, 3'h3: lim = 5'h04;
            3'h4, 3'h5: lim = 5'h08;
            3'h6, 3'h7: lim = 5'h10;
            default: lim = 5'h00;
        endcase
        if (hb == `MMSA_HBURST_INCR) begin
            case (ul)
                `MMSA_UBRK_4: lim = 5'h04;
                `MMSA_UBRK_8: lim = 5'h08;
                `MMSA_UBRK_16: lim = 5'h10;
                default: lim = 5'h00;
            endcase
        end

        // re-arbitration points
        at_bound = lim != 5'h00 && beat_next[s] == lim;
        slot_out = slot_lim_w[s] != 8'h00 && slot_next[s] == 8'h00;
        may_arb = !active;
        if (active && hready_in[s]) begin
            if (hb == `MMSA_HBURST_SINGLE) begin
                may_arb = 1'b1;
            end
            if (at_bound) begin
                may_arb = 1'b1;
                beat_next[s] = 5'h00;
            end
            if (slot_out) begin
                may_arb = 1'b1;
            end
        end

        if (may_arb && rq != 4'h0) begin
            found = 1'b0;
            sel = 2'h0;
            if (arb_fixed_w[s]) begin
                // highest priority wins
                bestp = 2'h0;
                for (k = 0; k < NM; k = k + 1) begin
                    pv = pri_reg[s][2*k +: 2];
                    if (rq[k] && (!found || pv > bestp)) begin
                        found = 1'b1;
                        bestp = pv;
                        sel = k[1:0];
                    end
                end
            end else begin
                // rotating search from last grant
                for (k = 1; k <= NM; k = k + 1) begin
                    m = (last_reg[s] + k) % NM;
                    if (rq[m] && !found) begin
                        found = 1'b1;
                        sel = m[1:0];
                    end
                end
            end
            grant_next[s*NM +: NM] = 4'h1 << sel;
            owned_next[s] = 1'b1;
            last_next[s] = sel;
            beat_next[s] = 5'h00;
        end else if (may_arb) begin
            case (defm_type_w[s])
                `MMSA_DEFM_LAST: begin
                    owned_next[s] = |grant_reg[s*NM +: NM];
                end
                `MMSA_DEFM_FIXED: begin
                    grant_next[s*NM +: NM] = 4'h1 << defm_id_w[s];
                    owned_next[s] = 1'b1;
                end
                default: begin
                    grant_next[s*NM +: NM] = 4'h0;
                    owned_next[s] = 1'b0;
                end
            endcase
        end
    end
end

// ==========================================
// arbitration state and outputs
integer q;

always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
        grant_reg <= 8'h00;
        owned_reg <= 2'h0;
        grant_out <= 8'h00;
        owned_out <= 2'h0;
        for (q = 0; q < NS; q = q + 1) begin
            last_reg[q] <= 2'h3; // first pick starts at master 0
            slot_reg[q] <= 8'h00;
            beat_reg[q] <= 5'h00;
        end
    end else begin
        grant_reg <= grant_next;
        owned_reg <= owned_next;
        grant_out <= grant_next;
        owned_out <= owned_next;
        for (q = 0; q < NS; q = q + 1) begin
            last_reg[q] <= last_next[q];
            slot_reg[q] <= slot_next[q];
            beat_reg[q] <= beat_next[q];
        end
    end
end

endmodule

/* verification/mmsa_checker.sv */
`timescale 1ns/100ps
`include "mmsa_defines.vh"
// ==========================================
// arbiter port checks
module mmsa_checker (
    // clock and reset
    input wire clk_sys_in,
    input wire nrst_in,
    // register port
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [31:0] reg_rdata_out,
    // arbitration
    input wire [7:0] req_in,
    input wire [3:0] htrans_in,
    input wire [5:0] hburst_in,
    input wire [1:0] hready_in,
    input wire [7:0] grant_out,
    input wire [1:0] owned_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    sequence s_wait1;
        owned_out[1] && htrans_in[3] && !hready_in[1] && hburst_in[5:3] != `MMSA_HBURST_SINGLE;
    endsequence
    sequence s_rd(logic [7:0] a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    AST_ONEHOT: assert property ($onehot0(grant_out[3:0]) && $onehot0(grant_out[7:4]))
        else $error("grant not one-hot");
    AST_OWNED: assert property (owned_out == {|grant_out[7:4], |grant_out[3:0]})
        else $error("owned flag mismatch");
    AST_IDLE0: assert property (!owned_out[0] && |req_in[3:0] |=> |(grant_out[3:0] & $past(req_in[3:0])))
        else $error("slave 0 idle request not granted");
    AST_IDLE1: assert property (!owned_out[1] && |req_in[7:4] |=> |(grant_out[7:4] & $past(req_in[7:4])))
        else $error("slave 1 idle request not granted");
    AST_HOLD: assert property (s_wait1 |=> $stable(grant_out[7:4]))
        else $error("grant moved in a waited beat");
    AST_RDZERO: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data outside read slot");
    AST_UNMAP: assert property (s_rd(8'h40) |=> reg_rdata_out == 32'h0)
        else $error("unmapped read not zero");
    AST_STATUS: assert property (
        s_rd(`MMSA_STAT_BASE) |=> reg_rdata_out[7] == $past(owned_out[0]) && reg_rdata_out[3:0] == $past(grant_out[3:0]))
        else $error("status does not mirror grant");
endmodule
bind mmsa_arbiter mmsa_checker u_chk (.*);

/* verification/mmsa_masters.sv */
`timescale 1ns/100ps
`include "mmsa_defines.vh"
// ==========================================
// bus master models
module mmsa_masters (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // bench commands
    input wire logic [7:0] start_in,
    input wire logic [4:0] len_in,
    input wire logic slow_in,
    // arbiter side
    input wire logic [7:0] grant_in,
    output logic [7:0] req_out,
    output logic [7:0] done_out,
    output logic [3:0] htrans_out,
    output logic [1:0] hready_out
);
    logic [4:0] rem_reg [8];
    logic [7:0] first_reg;
    logic tick_reg;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            req_out[i] = rem_reg[i] != 0;
        end
        for (int s = 0; s < 2; s++) begin
            htrans_out[2*s +: 2] = `MMSA_HTRANS_IDLE;
            hready_out[s] = !slow_in || tick_reg;
            for (int m = 0; m < 4; m++) begin
                if (grant_in[s*4+m] && rem_reg[s*4+m] != 0) begin
                    htrans_out[2*s +: 2] = first_reg[s*4+m] ? `MMSA_HTRANS_NSEQ : `MMSA_HTRANS_SEQ;
                end
            end
        end
    end
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            first_reg <= 8'hFF;
            tick_reg <= 1'b0;
            done_out <= 8'h00;
            rem_reg <= '{default: 5'h00};
        end else begin
            tick_reg <= !tick_reg;
            done_out <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                if (start_in[i]) begin
                    rem_reg[i] <= len_in;
                    first_reg[i] <= 1'b1;
                end else if (grant_in[i] && rem_reg[i] != 0 && hready_out[i/4]) begin
                    rem_reg[i] <= rem_reg[i] - 5'h01;
                    first_reg[i] <= 1'b0;
                    done_out[i] <= rem_reg[i] == 5'h01;
                end else if (!grant_in[i]) begin
                    first_reg[i] <= 1'b1;
                end
            end
        end
    end
endmodule

/* verification/mmsa_arbiter_test.sv */
`timescale 1ns/100ps
`include "mmsa_defines.vh"
module mmsa_arbiter_test;
    // ==========================================
    // stimulus
    logic clk_sys_in = 0;
    logic nrst_in = 0;
    logic reg_wr_in = 0;
    logic reg_rd_in = 0;
    logic slow = 0;
    logic hit = 0;
    logic [7:0] reg_addr_in = 0;
    logic [7:0] start = 0;
    logic [31:0] reg_wdata_in = 0;
    logic [5:0] hburst_in = {`MMSA_HBURST_INCR, `MMSA_HBURST_SINGLE};
    logic [4:0] len = 1;
    logic [31:0] reg_rdata_out;
    logic [7:0] req_in, grant_out, done;
    logic [3:0] htrans_in;
    logic [1:0] hready_in, owned_out;
    int error_cnt = 0, n_tests = 0, cyc = 0, beats = 0, q[$];
    logic [2:0] ub[4] = '{`MMSA_UBRK_4, `MMSA_UBRK_8, `MMSA_UBRK_16, `MMSA_UBRK_INF};
    int lim[4] = '{4, 8, 16, 20};
    always #5 clk_sys_in = !clk_sys_in;
    mmsa_arbiter u_dut (.*);
    mmsa_masters u_mst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .start_in(start), .len_in(len),
        .slow_in(slow), .grant_in(grant_out), .req_out(req_in), .done_out(done), .htrans_out(htrans_in),
        .hready_out(hready_in));
    // ==========================================
    // tasks
    task conclude();
        $display("compares %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1;
        @(posedge clk_sys_in);
        reg_wr_in <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1;
        @(posedge clk_sys_in);
        reg_rd_in <= 0;
        @(negedge clk_sys_in);
        chk(reg_rdata_out & m, e);
    endtask
    task run(input logic [7:0] a, b);
        q = {};
        @(posedge clk_sys_in);
        start <= a;
        @(posedge clk_sys_in);
        start <= b;
        @(posedge clk_sys_in);
        start <= 0;
        for (int i = 0; i < 500 && q.size() < $countones(a | b); i++) @(posedge clk_sys_in);
    endtask
    function logic [31:0] ord();
        ord = 0;
        foreach (q[i]) ord = {ord[27:0], q[i][3:0]};
    endfunction
    always @(posedge clk_sys_in) begin
        cyc++;
        foreach (done[i]) if (done[i]) q.push_back(i);
        if (grant_out[5]) hit = 1;
        if (grant_out[4] && htrans_in[3] && hready_in[1] && !hit) beats++;
        if (cyc > 20000) begin
            error_cnt++;
            conclude();
        end
    end
    // ==========================================
    // tests
    initial begin
        repeat (12) @(posedge clk_sys_in);
        nrst_in <= 1;
        rd(`MMSA_SCFG_BASE, `MMSA_SCFG_RESET);
        rd(`MMSA_MCFG_BASE, `MMSA_MCFG_RESET);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 0);
        $display("registers done");
        run(8'h0F, 0);
        chk(ord(), 32'h0123);
        run(8'h01, 0);
        run(8'h03, 0);
        chk(ord(), 32'h10);
        $display("round robin done");
        wr(`MMSA_PRI_BASE, 32'hC8);
        rd(`MMSA_PRI_BASE, 32'hC8);
        wr(`MMSA_SCFG_BASE, 32'h0100_0010);
        run(8'h0F, 0);
        chk(ord(), 32'h3102);
        wr(`MMSA_SCFG_BASE, 32'h010A_0010);
        repeat (4) @(posedge clk_sys_in);
        chk(grant_out[3:0], 4'b0100);
        rd(`MMSA_STAT_BASE, 32'h84, 32'hBF);
        wr(`MMSA_SCFG_BASE, 32'h0001_0010);
        run(8'h02, 0);
        repeat (4) @(posedge clk_sys_in);
        chk(grant_out[3:0], 4'b0010);
        $display("priority and default done");
        wr(`MMSA_SCFG_BASE + 8'h04, 0);
        len <= 20;
        for (int k = 0; k < 4; k++) begin
            wr(`MMSA_MCFG_BASE, ub[k]);
            slow <= k[0];
            beats = 0;
            hit = 0;
            run(8'h10, 8'h20);
            chk(beats, lim[k]);
        end
        wr(`MMSA_SCFG_BASE + 8'h04, 5);
        slow <= 0;
        beats = 0;
        hit = 0;
        run(8'h10, 8'h20);
        chk(beats, 6);
        $display("burst breaks done");
        conclude();
    end
endmodule
